// ### gpcp_assertions.sv
// assertion checker of the gpio port with pin change flags
`timescale 1ns/1ps
module gpcp_assertions (
  // watched top ports
  input wire logic                      i_core_clk,
  input wire logic                      i_reset_n,
  input wire logic                      i_read,
  input wire logic                      i_write,
  input wire logic [31:0]               o_readdata,
  input wire logic                      o_waitrequest,
  input wire logic                      i_global_irq_en,
  input wire logic [3:0]                i_vector_ack,
  input wire logic [3:0]                o_irq_req,
  input wire logic [31:0]               i_pin,
  input wire gpcp_pkg::gpcp_pin_drive_t o_pin_drive
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_req; (i_read || i_write) && o_waitrequest; endsequence
  sequence s_ans; !o_waitrequest ##1 o_waitrequest; endsequence
  sequence s_calm; $stable(i_pin) [*8]; endsequence
  property p_bus; s_req |=> s_ans; endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
  property p_idle; !(i_read || i_write) |=> o_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_rdhi; i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h0;
  endproperty
  a_rdhi: assert property (p_rdhi) else $error("upper bits set");
  property p_gie; !i_global_irq_en |=> o_irq_req == 4'h0; endproperty
  a_gie: assert property (p_gie) else $error("request unmasked");
  property p_pull;
    (o_pin_drive.pull & (o_pin_drive.oe | ~o_pin_drive.out)) == 32'h0;
  endproperty
  a_pull: assert property (p_pull) else $error("bad pull-up");
  property p_rst; disable iff (1'b0) !i_reset_n |=>
    {o_pin_drive.oe, o_pin_drive.pull} == 64'h0; endproperty
  a_rst: assert property (p_rst) else $error("pads not idle");
  property p_drv;
    $changed(o_pin_drive) |-> $past(i_write, 2) && !$past(o_waitrequest, 2);
  endproperty
  a_drv: assert property (p_drv) else $error("drive moved alone");
  property p_ack; s_calm ##0 (i_vector_ack != 4'h0) |->
    ##3 (o_irq_req & $past(i_vector_ack, 3)) == 4'h0; endproperty
  a_ack: assert property (p_ack) else $error("ack kept request");
endmodule

bind gpcp_top gpcp_assertions u_chk (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_read(i_read),
  .i_write(i_write), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .i_global_irq_en(i_global_irq_en),
  .i_vector_ack(i_vector_ack), .o_irq_req(o_irq_req), .i_pin(i_pin),
  .o_pin_drive(o_pin_drive));

// ### gpcp_pin_model.sv
// model of the pads and the outside sources behind them
`timescale 1ns/1ps
module gpcp_pin_model (
  // pad drive from the port
  input  wire gpcp_pkg::gpcp_pin_drive_t i_drive,
  // level of the strong outside source
  input  wire logic [31:0]               i_ext_val,
  // level seen at each pad
  output logic [31:0]                    o_pin
);
  assign o_pin = (i_drive.oe & i_drive.out) | (~i_drive.oe & i_ext_val);
endmodule

// ### gpcp_pkg.sv
// constants, types and register map of the gpio port with pin change flags
package gpcp_pkg;
  localparam int NPORT    = 4;
  localparam int PORT_W   = 8;
  localparam int NPIN     = 32;
  localparam int NGROUP   = 4;
  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 32;
  localparam int IDX_W    = 8;
  localparam int SEL_W    = 5;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_IN_BASE     = 8'h00;
  localparam logic [7:0] IDX_DIR_BASE    = 8'h01;
  localparam logic [7:0] IDX_OUT_BASE    = 8'h02;
  localparam logic [7:0] IDX_PORT_STRIDE = 8'h03;
  localparam logic [7:0] IDX_MCU_CTRL    = 8'h35;
  localparam logic [7:0] IDX_GRP_FLAGS   = 8'h3b;
  localparam logic [7:0] IDX_BIT_OP      = 8'h3c;
  localparam logic [7:0] IDX_GRP_CTRL    = 8'h68;
  localparam logic [7:0] IDX_MASK0       = 8'h6b;
  localparam logic [7:0] IDX_MASK1       = 8'h6c;
  localparam logic [7:0] IDX_MASK2       = 8'h6d;
  localparam logic [7:0] IDX_MASK3       = 8'h73;

  // field positions
  localparam int PUD_BIT      = 4;
  localparam int BOP_PIN_LSB  = 0;
  localparam int BOP_PORT_LSB = 3;
  localparam int BOP_TGT_LSB  = 5;
  localparam int BOP_SET_BIT  = 7;

  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0]  RST_NIB  = 4'h0;

  // target of a single-bit operation
  typedef enum logic [1:0] {
    BOP_DIR,
    BOP_OUT,
    BOP_TOGGLE,
    BOP_NONE
  } gpcp_bop_tgt_t;

  // drive towards the pad ring
  typedef struct packed {
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] pull;
  } gpcp_pin_drive_t;
endpackage

// ### gpcp_top.sv
// four 8-bit gpio ports with pin change group flags on avalon-mm
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module gpcp_top (
  // clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_reset_n,
  // avalon-mm slave
  input  wire logic [gpcp_pkg::ADDR_W-1:0] i_address,
  input  wire logic                     i_read,
  input  wire logic                     i_write,
  input  wire logic [3:0]               i_byteenable,
  input  wire logic [gpcp_pkg::DATA_W-1:0] i_writedata,
  output logic [gpcp_pkg::DATA_W-1:0]   o_readdata,
  output logic                          o_waitrequest,
  // processor interrupt side
  input  wire logic                     i_global_irq_en,
  input  wire logic [3:0]               i_vector_ack,
  output logic [3:0]                    o_irq_req,
  // pins
  input  wire logic [gpcp_pkg::NPIN-1:0] i_pin,
  output gpcp_pkg::gpcp_pin_drive_t     o_pin_drive
);

  logic                          wait_q;
  logic [gpcp_pkg::DATA_W-1:0]   rdata_q;
  logic [gpcp_pkg::NPIN-1:0]     dir_q;
  logic [gpcp_pkg::NPIN-1:0]     dir_d;
  logic [gpcp_pkg::NPIN-1:0]     out_q;
  logic [gpcp_pkg::NPIN-1:0]     out_d;
  logic                          pud_q;
  logic [3:0]                    grp_en_q;
  logic [3:0]                    flag_q;
  logic [3:0]                    flag_d;
  logic [3:0]                    grp_set;
  logic [3:0]                    grp_clr;
  logic [3:0]                    irq_q;
  logic [7:0]                    mask_q [gpcp_pkg::NGROUP];
  logic [gpcp_pkg::NPIN-1:0]     sync1_q;
  logic [gpcp_pkg::NPIN-1:0]     sync2_q;
  logic [gpcp_pkg::NPIN-1:0]     sync3_q;
  logic [gpcp_pkg::NPIN-1:0]     pin_q;
  logic [gpcp_pkg::NPIN-1:0]     prev_q;
  logic [gpcp_pkg::NPIN-1:0]     agree;
  logic [gpcp_pkg::NPIN-1:0]     change;
  gpcp_pkg::gpcp_pin_drive_t     drive_q;
  logic [gpcp_pkg::IDX_W-1:0]    idx;
  logic [7:0]                    wb;
  logic                          wr_go;
  logic                          rd_go;
  logic [gpcp_pkg::DATA_W-1:0]   rd_mux;
  logic [gpcp_pkg::SEL_W-1:0]    bop_sel;
  gpcp_pkg::gpcp_bop_tgt_t       bop_tgt;

  assign idx     = i_address[gpcp_pkg::ADDR_W-1:2];
  assign wb      = i_writedata[7:0];
  // writes take effect at the edge where waitrequest is seen low
  assign wr_go   = i_write & ~wait_q & i_byteenable[0];
  assign rd_go   = i_read & wait_q;
  assign bop_sel = wb[gpcp_pkg::BOP_TGT_LSB-1:gpcp_pkg::BOP_PIN_LSB];
  assign bop_tgt = gpcp_pkg::gpcp_bop_tgt_t'(
                     wb[gpcp_pkg::BOP_SET_BIT-1:gpcp_pkg::BOP_TGT_LSB]);

  // bus handshake: one wait cycle, then the answer
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((i_read | i_write) & wait_q);
    end
  end

  // next direction and output data
  always_comb begin
    dir_d = dir_q;
    out_d = out_q;
    for (int p = 0; p < gpcp_pkg::NPORT; p++) begin
      if (wr_go && idx == 8'(gpcp_pkg::IDX_DIR_BASE
                             + gpcp_pkg::IDX_PORT_STRIDE * p)) begin
        dir_d[p*gpcp_pkg::PORT_W +: gpcp_pkg::PORT_W] = wb;
      end
      if (wr_go && idx == 8'(gpcp_pkg::IDX_OUT_BASE
                             + gpcp_pkg::IDX_PORT_STRIDE * p)) begin
        out_d[p*gpcp_pkg::PORT_W +: gpcp_pkg::PORT_W] = wb;
      end
      if (wr_go && idx == 8'(gpcp_pkg::IDX_IN_BASE
                             + gpcp_pkg::IDX_PORT_STRIDE * p)) begin
        out_d[p*gpcp_pkg::PORT_W +: gpcp_pkg::PORT_W] =
          out_q[p*gpcp_pkg::PORT_W +: gpcp_pkg::PORT_W] ^ wb;
      end
    end
    if (wr_go && idx == gpcp_pkg::IDX_BIT_OP) begin
      case (bop_tgt)
        gpcp_pkg::BOP_DIR: begin
          dir_d[bop_sel] = wb[gpcp_pkg::BOP_SET_BIT];
        end
        gpcp_pkg::BOP_OUT: begin
          out_d[bop_sel] = wb[gpcp_pkg::BOP_SET_BIT];
        end
        gpcp_pkg::BOP_TOGGLE: begin
          out_d[bop_sel] = ~out_q[bop_sel];
        end
        default: begin
          dir_d = dir_q;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      dir_q <= gpcp_pkg::RST_WORD;
      out_q <= gpcp_pkg::RST_WORD;
    end else begin
      dir_q <= dir_d;
      out_q <= out_d;
    end
  end

  // control registers
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      pud_q    <= 1'b0;
      grp_en_q <= gpcp_pkg::RST_NIB;
    end else begin
      if (wr_go && idx == gpcp_pkg::IDX_MCU_CTRL) begin
        pud_q <= wb[gpcp_pkg::PUD_BIT];
      end
      if (wr_go && idx == gpcp_pkg::IDX_GRP_CTRL) begin
        grp_en_q <= wb[3:0];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      for (int g = 0; g < gpcp_pkg::NGROUP; g++) begin
        mask_q[g] <= gpcp_pkg::RST_BYTE;
      end
    end else if (wr_go) begin
      case (idx)
        gpcp_pkg::IDX_MASK0: begin
          mask_q[0] <= wb;
        end
        gpcp_pkg::IDX_MASK1: begin
          mask_q[1] <= wb;
        end
        gpcp_pkg::IDX_MASK2: begin
          mask_q[2] <= wb;
        end
        gpcp_pkg::IDX_MASK3: begin
          mask_q[3] <= wb;
        end
        default: begin
          mask_q[0] <= mask_q[0];
        end
      endcase
    end
  end

  assign agree = ~(sync2_q ^ sync3_q);
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sync1_q <= gpcp_pkg::RST_WORD;
      sync2_q <= gpcp_pkg::RST_WORD;
      sync3_q <= gpcp_pkg::RST_WORD;
      pin_q   <= gpcp_pkg::RST_WORD;
      prev_q  <= gpcp_pkg::RST_WORD;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q   <= (sync3_q & agree) | (pin_q & ~agree);
      prev_q  <= pin_q;
    end
  end

  assign change = pin_q ^ prev_q;

  // group set and clear terms
  always_comb begin
    for (int g = 0; g < gpcp_pkg::NGROUP; g++) begin
      grp_set[g] = grp_en_q[g]
                   & |(change[g*gpcp_pkg::PORT_W +: gpcp_pkg::PORT_W]
                       & mask_q[g]);
      grp_clr[g] = (wr_go && idx == gpcp_pkg::IDX_GRP_FLAGS && wb[g])
                   | i_vector_ack[g];
    end
    flag_d = grp_set | (flag_q & ~grp_clr);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      flag_q <= gpcp_pkg::RST_NIB;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      irq_q <= gpcp_pkg::RST_NIB;
    end else begin
      irq_q <= flag_q & grp_en_q & {4{i_global_irq_en}};
    end
  end

  // pin drive
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      drive_q.oe   <= gpcp_pkg::RST_WORD;
      drive_q.out  <= gpcp_pkg::RST_WORD;
      drive_q.pull <= gpcp_pkg::RST_WORD;
    end else begin
      drive_q.oe   <= dir_q;
      drive_q.out  <= out_q;
      drive_q.pull <= ~dir_q & out_q & {gpcp_pkg::NPIN{~pud_q}};
    end
  end

  // read mux
  always_comb begin
    rd_mux = gpcp_pkg::RST_WORD;
    case (idx)
      gpcp_pkg::IDX_MCU_CTRL: begin
        rd_mux[gpcp_pkg::PUD_BIT] = pud_q;
      end
      gpcp_pkg::IDX_GRP_FLAGS: begin
        rd_mux[3:0] = flag_q;
      end
      gpcp_pkg::IDX_GRP_CTRL: begin
        rd_mux[3:0] = grp_en_q;
      end
      gpcp_pkg::IDX_MASK0: begin
        rd_mux[7:0] = mask_q[0];
      end
      gpcp_pkg::IDX_MASK1: begin
        rd_mux[7:0] = mask_q[1];
      end
      gpcp_pkg::IDX_MASK2: begin
        rd_mux[7:0] = mask_q[2];
      end
      gpcp_pkg::IDX_MASK3: begin
        rd_mux[7:0] = mask_q[3];
      end
      default: begin
        rd_mux = gpcp_pkg::RST_WORD;
      end
    endcase
    for (int p = 0; p < gpcp_pkg::NPORT; p++) begin
      if (idx == 8'(gpcp_pkg::IDX_IN_BASE
                    + gpcp_pkg::IDX_PORT_STRIDE * p)) begin
        rd_mux[7:0] = pin_q[p*gpcp_pkg::PORT_W +: gpcp_pkg::PORT_W];
      end
      if (idx == 8'(gpcp_pkg::IDX_DIR_BASE
                    + gpcp_pkg::IDX_PORT_STRIDE * p)) begin
        rd_mux[7:0] = dir_q[p*gpcp_pkg::PORT_W +: gpcp_pkg::PORT_W];
      end
      if (idx == 8'(gpcp_pkg::IDX_OUT_BASE
                    + gpcp_pkg::IDX_PORT_STRIDE * p)) begin
        rd_mux[7:0] = out_q[p*gpcp_pkg::PORT_W +: gpcp_pkg::PORT_W];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      rdata_q <= gpcp_pkg::RST_WORD;
    end else if (rd_go) begin
      rdata_q <= rd_mux;
    end
  end

  assign o_readdata    = rdata_q;
  assign o_waitrequest = wait_q;
  assign o_irq_req     = irq_q;
  assign o_pin_drive   = drive_q;

endmodule

// ### tb_gpio_port_with_pin_change_irq.sv
// self-checking bench of the gpio port with pin change flags
`timescale 1ns/1ps
module tb_gpio_port_with_pin_change_irq;
  localparam logic [7:0] FLG = 8'h3b, CTL = 8'h68, BOP = 8'h3c;
  localparam logic [7:0] MIDX [4] = '{8'h6b, 8'h6c, 8'h6d, 8'h73};
  logic        i_core_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [9:0]  i_address = 10'h000;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic        i_global_irq_en = 1'b1;
  logic [3:0]  i_vector_ack = 4'h0;
  logic [3:0]  o_irq_req;
  logic [31:0] i_pin;
  logic [31:0] ext_val = 32'h0;
  logic [7:0]  rd;
  int          bad_count = 0;
  int          n_checks = 0;
  gpcp_pkg::gpcp_pin_drive_t o_pin_drive;
  gpcp_top uut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_byteenable(4'h1), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_global_irq_en(i_global_irq_en), .i_vector_ack(i_vector_ack),
    .o_irq_req(o_irq_req), .i_pin(i_pin), .o_pin_drive(o_pin_drive));
  gpcp_pin_model pins (.i_drive(o_pin_drive), .i_ext_val(ext_val),
    .o_pin(i_pin));
  always #20 i_core_clk = ~i_core_clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // one avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    int n;
    {i_write, i_read} <= {w, !w};
    i_address <= {a, 2'b00};
    i_writedata <= {24'h0, d};
    for (n = 0; n < 50; n++) begin
      @(posedge i_core_clk);
      if (o_waitrequest === 1'b0) break;
    end
    rd = o_readdata[7:0];
    {i_write, i_read} <= 2'b00;
    @(posedge i_core_clk);
    if (n == 50) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({24'h0, rd}, {24'h0, e});
  endtask
  task automatic wait_irq(input int g, input logic v);
    int n;
    for (n = 0; n < 20 && o_irq_req[g] !== v; n++) @(posedge i_core_clk);
    chk({31'h0, o_irq_req[g]}, {31'h0, v});
    if (n == 20) summarize();
  endtask
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      rc(MIDX[i], 8'h00);
      bus(1'b1, MIDX[i], 8'h5a + 8'(i));
      rc(MIDX[i], 8'h5a + 8'(i));
    end
    rc(CTL, 8'h00);
    bus(1'b1, CTL, 8'hff);
    rc(CTL, 8'h0f);
    bus(1'b1, CTL, 8'h00);
    rc(8'h50, 8'h00);
    bus(1'b1, 8'h02, 8'h0f);
    bus(1'b1, 8'h00, 8'h3c);
    rc(8'h02, 8'h33);
    rc(8'h00, 8'h00);
  endtask
  task automatic t_drive();
    bus(1'b1, 8'h04, 8'hf0);
    bus(1'b1, 8'h05, 8'haa);
    @(posedge i_core_clk);
    chk(o_pin_drive.oe, 32'h0000_f000);
    chk(o_pin_drive.out, 32'h0000_aa33);
    chk(o_pin_drive.pull, 32'h0000_0a33);
    bus(1'b1, 8'h35, 8'h10);
    @(posedge i_core_clk);
    chk(o_pin_drive.pull, 32'h0);
    bus(1'b1, 8'h35, 8'h00);
    rc(8'h03, 8'ha0);
  endtask
  task automatic t_bitop();
    bus(1'b1, BOP, 8'h93);
    bus(1'b1, BOP, 8'hb7);
    bus(1'b1, BOP, 8'hd0);
    rc(8'h07, 8'h08);
    rc(8'h08, 8'h81);
  endtask
  task automatic t_change();
    bus(1'b1, FLG, 8'h0f);
    for (int g = 0; g < 4; g++) begin
      bus(1'b1, MIDX[g], 8'h01);
      bus(1'b1, CTL, 8'h01 << g);
      ext_val[8*g+1] <= ~ext_val[8*g+1];
      repeat (8) @(posedge i_core_clk);
      rc(FLG, 8'h00);
      ext_val[8*g] <= ~ext_val[8*g];
      wait_irq(g, 1'b1);
      bus(1'b1, FLG, 8'h00);
      rc(FLG, 8'h01 << g);
      bus(1'b1, FLG, 8'h01 << g);
      rc(FLG, 8'h00);
      ext_val[8*g] <= ~ext_val[8*g];
      wait_irq(g, 1'b1);
      repeat (6) @(posedge i_core_clk);
      i_vector_ack[g] <= 1'b1;
      @(posedge i_core_clk);
      i_vector_ack <= 4'h0;
      wait_irq(g, 1'b0);
      rc(FLG, 8'h00);
    end
  endtask
  task automatic t_gie();
    i_global_irq_en <= 1'b0;
    bus(1'b1, CTL, 8'h01);
    ext_val[0] <= ~ext_val[0];
    repeat (10) @(posedge i_core_clk);
    chk({28'h0, o_irq_req}, 32'h0);
    rc(FLG, 8'h01);
    i_global_irq_en <= 1'b1;
    wait_irq(0, 1'b1);
    bus(1'b1, CTL, 8'h00);
    wait_irq(0, 1'b0);
  endtask
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    t_regs();
    t_drive();
    t_bitop();
    t_change();
    t_gie();
    summarize();
  end
endmodule
